/* File: bench/ddrtm_chk_monitor.sv */
// Checker for the timing block: bus handshake, termination delays, flags.
// Assumes the check enable bit stays set and command pins share clk.
`timescale 1ns/1ns
module ddrtm_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        mem_cke,
    input wire logic        mem_cs_n,
    input wire logic        mem_ras_n,
    input wire logic        mem_cas_n,
    input wire logic        mem_we_n,
    input wire logic        mem_odt,
    input wire logic        term_en,
    input wire logic        viol_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic clr_q;
    // Data phase of a write to the violation register
    always @(posedge clk) begin
        clr_q <= rst_n && hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h08;
    end
    sequence s_mrs;
        mem_cke && $past(mem_cke) && !mem_cs_n && !mem_ras_n && !mem_cas_n && !mem_we_n;
    endsequence
    sequence s_rd;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_wr;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    a_reset_values: assert property (disable iff (1'b0) !rst_n |=> hreadyout && !term_en
        && !viol_flag && hrdata == 32'h0) else $error("reset values wrong");
    a_resp_okay: assert property (!hresp) else $error("response not okay");
    a_read_wait: assert property (s_rd |=> !hreadyout ##1 hreadyout) else $error("read wait");
    a_write_nowait: assert property (s_wr |=> hreadyout) else $error("write wait");
    a_term_on: assert property ($rose(mem_odt) ##1 mem_odt[*2] |=> term_en)
        else $error("termination on late");
    a_term_off: assert property ($fell(mem_odt) ##1 (!mem_odt)[*3] |=> !term_en)
        else $error("termination off late");
    a_mode_gap: assert property (s_mrs ##1 s_mrs |=> viol_flag)
        else $error("mode set gap not flagged");
    a_cke_hold: assert property ($changed(mem_cke) ##1 $changed(mem_cke) |=> viol_flag)
        else $error("clock enable hold not flagged");
    a_flag_sticky: assert property (viol_flag && !clr_q |=> viol_flag)
        else $error("flag lost without clear");
endmodule // ddrtm_chk

bind ddrtm_monitor ddrtm_chk chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_odt(mem_odt), .term_en(term_en), .viol_flag(viol_flag));

/* File: bench/ddrtm_ctl_model.sv */
// Controller model driving the command pins; spacing is set by the caller.
// Assumes tasks are called from one process, changes land after clk edges.
`timescale 1ns/1ns
module ddrtm_ctl_model (
    input  wire logic        clk,
    output logic        cke,
    output logic        cs_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic [1:0]  ba,
    output logic [13:0] addr,
    output logic        odt
);
    // Idle levels at time zero
    initial begin
        cke = 1'b0;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        ba = 2'h0;
        addr = 14'h0;
        odt = 1'b0;
    end
    // clock never retimed, no refresh skipped, no data driven
    // Deselect; address toggles so no stale value lingers
    task idle(input int n);
        repeat (n) begin
            @(posedge clk);
            cs_n <= 1'b1;
            {ras_n, cas_n, we_n} <= 3'h7;
            addr <= ~addr;
        end
    endtask
    task cmd(input logic [2:0] k, input logic [1:0] b, input logic [13:0] a, input int gap);
        @(posedge clk);
        cs_n <= 1'b0;
        {ras_n, cas_n, we_n} <= k;
        ba <= b;
        addr <= a;
        idle(gap - 1);
    endtask
    // level held for the asked edges
    task ckeset(input logic v, input int hold);
        @(posedge clk);
        cke <= v;
        repeat (hold - 1) @(posedge clk);
    endtask
    // Termination control change
    task odtset(input logic v);
        @(posedge clk);
        odt <= v;
    endtask
endmodule // ddrtm_ctl_model

/* File: bench/ddrtm_monitor_tb.sv */
// Testbench for the timing block: registers over AHB-Lite, command spacing,
// termination delays. Assumes the checker is bound to the top module.
`timescale 1ns/1ns
module ddrtm_monitor_tb;
    logic        clk, rst_n, hsel, hwrite;
    logic [31:0] haddr, hwdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire         hreadyout, hresp, term_en, viol_flag, cke, cs_n, ras_n, cas_n, we_n, odt;
    wire  [31:0] hrdata;
    wire  [1:0]  ba;
    wire  [13:0] addr;
    int          err_count, checks_done;
    localparam int RP = (15000 + 3999) / 4000;
    localparam int RAS = (40000 + 3999) / 4000;
    localparam int RTP = (8000 + 3999) / 4000;

    ddrtm_monitor uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .mem_cke(cke), .mem_cs_n(cs_n), .mem_ras_n(ras_n), .mem_cas_n(cas_n),
        .mem_we_n(we_n), .mem_ba(ba), .mem_addr(addr), .mem_odt(odt),
        .term_en(term_en), .viol_flag(viol_flag));
    ddrtm_ctl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Counts and prints the verdict
    task results;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bounded wait for ready at a rising edge
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            err_count++;
            results();
        end
    endtask
    // One single word transfer; read data lands in q
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    // Register reset values, access kinds, unmapped place
    task t_regs;
        bus(0, 32'h0, 0); check(q, 32'h1);
        bus(0, 32'h4, 0); check(q, (RTP << 16) | (RAS << 8) | RP);
        bus(1, 32'h0, 32'h3); bus(0, 32'h0, 0); check(q, 32'h3);
        bus(1, 32'h0, 32'h1);
        bus(1, 32'hc, 32'hffffffff); bus(0, 32'hc, 0); check(q, 32'h3042);
        bus(1, 32'h10, 32'h5); bus(0, 32'h10, 0); check(q, 32'h0);
        bus(0, 32'h8, 0); check(q, 32'h0);
    endtask
    // Mode programming and mode set spacing
    task t_mode;
        ctl.ckeset(1'b1, 4);
        ctl.cmd(3'h0, 2'h0, 14'h1653, 2);
        ctl.cmd(3'h0, 2'h1, 14'h0400, 2);
        bus(0, 32'hc, 0); check(q, 32'h000b3053);
        bus(0, 32'h8, 0); check(q, 32'h0);
        ctl.cmd(3'h0, 2'h0, 14'h1653, 1);
        ctl.cmd(3'h0, 2'h0, 14'h1653, 2);
        bus(0, 32'h8, 0); check(q & 32'h1, 32'h1);
        bus(1, 32'h8, 32'h3ff); bus(0, 32'h8, 0); check(q, 32'h0);
    endtask
    // Slow exit to read, then a short clock enable pulse
    task t_exit;
        ctl.cmd(3'h3, 2'h0, 14'h0, 2);
        ctl.ckeset(1'b0, 3);
        ctl.ckeset(1'b1, 3);
        ctl.cmd(3'h5, 2'h0, 14'h0, 2);
        bus(0, 32'h8, 0); check(q & 32'h40, 32'h40);
        bus(1, 32'h8, 32'h3ff);
        ctl.ckeset(1'b0, 3);
        ctl.ckeset(1'b1, 8);
        ctl.cmd(3'h5, 2'h0, 14'h0, 2);
        bus(0, 32'h8, 0); check(q, 32'h0);
        ctl.ckeset(1'b0, 1);
        ctl.ckeset(1'b1, 4);
        bus(0, 32'h8, 0); check(q & 32'h2, 32'h2);
        bus(1, 32'h8, 32'h3ff);
    endtask
    // Write to read, read to precharge, auto-precharge spacing
    task t_spacing;
        ctl.cmd(3'h4, 2'h0, 14'h0, 1);
        ctl.cmd(3'h5, 2'h0, 14'h0, 2);
        bus(0, 32'h8, 0); check(q & 32'h4, 32'h4);
        bus(1, 32'h8, 32'h3ff);
        ctl.cmd(3'h4, 2'h0, 14'h0, 12);
        ctl.cmd(3'h5, 2'h0, 14'h0, 1);
        ctl.cmd(3'h2, 2'h0, 14'h0, 2);
        bus(0, 32'h8, 0); check(q & 32'hc, 32'h8);
        bus(1, 32'h8, 32'h3ff);
        ctl.cmd(3'h3, 2'h0, 14'h0, 12);
        ctl.cmd(3'h5, 2'h0, 14'h0, 4);
        ctl.cmd(3'h2, 2'h0, 14'h0, 2);
        bus(0, 32'h8, 0); check(q, 32'h0);
        ctl.cmd(3'h3, 2'h0, 14'h0, 12);
        ctl.cmd(3'h4, 2'h0, 14'h0400, 2);
        ctl.cmd(3'h3, 2'h0, 14'h0, 2);
        bus(0, 32'h8, 0); check(q & 32'h200, 32'h200);
        check(viol_flag, 1'b1);
        bus(1, 32'h8, 32'h3ff);
    endtask
    // Termination change near power-down entry and exit, top grade exit
    task t_pd;
        bus(1, 32'h0, 32'h3);
        ctl.odtset(1'b1);
        ctl.ckeset(1'b0, 3);
        ctl.ckeset(1'b1, 2);
        ctl.cmd(3'h2, 2'h1, 14'h0, 2);
        ctl.odtset(1'b0);
        bus(0, 32'h8, 0); check(q, 32'h1a0);
        bus(1, 32'h8, 32'h3ff);
        bus(1, 32'h0, 32'h1);
    endtask
    // Termination on and off delays at exact edges
    task t_odt;
        ctl.odtset(1'b1);
        repeat (3) @(posedge clk);
        check(term_en, 1'b0);
        @(posedge clk);
        check(term_en, 1'b1);
        ctl.odtset(1'b0);
        repeat (4) @(posedge clk);
        check(term_en, 1'b1);
        @(posedge clk);
        check(term_en, 1'b0);
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        err_count = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_mode();
        t_exit();
        t_spacing();
        t_pd();
        t_odt();
        results();
    end
endmodule // ddrtm_monitor_tb

/* File: verilog/ddrtm_ahb_slave.v */
// AHB-Lite slave front end: captures the address phase, gives a write
// strobe in the data phase and one wait state on reads.
// Assumes a single master; hresp is always OKAY.
`timescale 1ns/1ns

module ddrtm_ahb_slave (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    output wire        wr_en,
    output wire [7:0]  reg_addr,
    output wire [31:0] wr_data,
    input  wire [31:0] rd_data
);

    reg       wr_pend_reg;
    reg       rd_pend_reg;
    reg [7:0] addr_reg;

    wire take = hsel & htrans[1] & hready;

    // Address phase capture and read wait state
    always @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
            hreadyout   <= 1'b1;
            hrdata      <= 32'h0000_0000;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= take & hwrite;
            rd_pend_reg <= take & ~hwrite;
            hresp       <= 1'b0;
            if (take) begin
                addr_reg <= haddr[7:0];
            end
            if (take & ~hwrite) begin
                hreadyout <= 1'b0;
            end else if (rd_pend_reg) begin
                hreadyout <= 1'b1;
                hrdata    <= rd_data;
            end
        end
    end

    assign wr_en    = wr_pend_reg;
    assign reg_addr = addr_reg;
    assign wr_data  = hwdata;

endmodule // ddrtm_ahb_slave

/* File: verilog/ddrtm_defs.vh */
// Constants for the DDR2 command timing monitor: register map, field
// positions, reset values and cycle counts derived from nanosecond times.
// Assumes a 250 MHz core clock that is also the memory input clock.
`ifndef DDRTM_DEFS_VH
`define DDRTM_DEFS_VH

// Register byte offsets
`define DDRTM_CTRL_OFS     8'h00
`define DDRTM_TIMING_OFS   8'h04
`define DDRTM_VIOL_OFS     8'h08
`define DDRTM_MODE_OFS     8'h0c

// Control register fields
`define DDRTM_CTRL_CHECK_BIT  0
`define DDRTM_CTRL_SPEED_BIT  1
`define DDRTM_CTRL_RESET      2'h1

// Timing register fields
`define DDRTM_TIM_RP_LSB   0
`define DDRTM_TIM_RAS_LSB  8
`define DDRTM_TIM_RTP_LSB  16

// Clock period and nanosecond times
`define DDRTM_CLK_PS       4000
`define DDRTM_TRP_NS       15
`define DDRTM_ACTIVATE_TO_PRECHARGE_MIN_NS      40
`define DDRTM_READ_TO_PRECHARGE_GAP_NS      8

// Cycle counts, rounded up from the nanosecond figures
`define DDRTM_RP_CYC   ((`DDRTM_TRP_NS * 1000 + `DDRTM_CLK_PS - 1) / `DDRTM_CLK_PS)
`define DDRTM_RAS_CYC  ((`DDRTM_ACTIVATE_TO_PRECHARGE_MIN_NS * 1000 + `DDRTM_CLK_PS - 1) / `DDRTM_CLK_PS)
`define DDRTM_RTP_CYC  ((`DDRTM_READ_TO_PRECHARGE_GAP_NS * 1000 + `DDRTM_CLK_PS - 1) / `DDRTM_CLK_PS)

// Fixed edge counts
`define DDRTM_MRS_GAP      6'd2
`define DDRTM_CKE_HOLD     6'd3
`define DDRTM_WTR_GAP      6'd2
`define DDRTM_XP_LOW       6'd2
`define DDRTM_XP_HIGH      6'd3
`define DDRTM_XARD_FAST    6'd2
`define DDRTM_XARDS_BASE   6'd8
`define DDRTM_ANPD_GAP     6'd3
`define DDRTM_AXPD_GAP     6'd8

// Mode register reset values and fields
`define DDRTM_BL_RESET     3'h2
`define DDRTM_CL_RESET     3'h4
`define DDRTM_AL_RESET     3'h0
`define DDRTM_WR_RESET     3'h3
`define DDRTM_BL8_CODE     3'h3
`define DDRTM_MR_SLOW_BIT     12
`define DDRTM_EMR_STROBE_BIT  10

// Violation flag positions
`define DDRTM_V_MRS    0
`define DDRTM_V_CKE    1
`define DDRTM_V_WTR    2
`define DDRTM_V_RTP    3
`define DDRTM_V_RAS    4
`define DDRTM_V_XP     5
`define DDRTM_V_XARD   6
`define DDRTM_V_ANPD   7
`define DDRTM_V_AXPD   8
`define DDRTM_V_DAL    9
`define DDRTM_V_BITS   10

`endif

/* File: verilog/ddrtm_gap_timer.v */
// Spacing counter: after a load, busy stays high until the loaded
// number of rising edges has passed since the loading command.
// Assumes load is a one-cycle strobe on the same clock.
`timescale 1ns/1ns

module ddrtm_gap_timer #(
    parameter W = 6
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         load,
    input  wire [W-1:0] value,
    output wire         busy
);

    reg [W-1:0] cnt_reg;
    reg [W-1:0] cnt_next;

    always @* begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = value;
        end else if (cnt_reg != {W{1'b0}}) begin
            cnt_next = cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= {W{1'b0}};
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Command at load edge plus value is the first legal one
    assign busy = (cnt_reg > {{(W-1){1'b0}}, 1'b1});

endmodule // ddrtm_gap_timer

/* File: verilog/ddrtm_monitor.v */
// DDR2 device-side command timing block: decodes commands, keeps mode
// register state, drives on-die termination and flags spacing faults.
// Assumes command pins come from controller logic on the same clock.
`timescale 1ns/1ns
`include "ddrtm_defs.vh"

module ddrtm_monitor #(
    parameter TW = 6
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output wire        hreadyout,
    output wire [31:0] hrdata,
    output wire        hresp,
    input  wire        mem_cke,
    input  wire        mem_cs_n,
    input  wire        mem_ras_n,
    input  wire        mem_cas_n,
    input  wire        mem_we_n,
    input  wire [1:0]  mem_ba,
    input  wire [13:0] mem_addr,
    input  wire        mem_odt,
    output reg         term_en,
    output reg         viol_flag
);

    // Bus side
    wire        wr_en;
    wire [7:0]  reg_addr;
    wire [31:0] wr_data;
    reg  [31:0] rd_data;

    // Software registers
    reg  [1:0]  ctrl_reg;
    reg  [4:0]  rp_reg;
    reg  [4:0]  ras_reg;
    reg  [3:0]  rtp_reg;
    reg  [`DDRTM_V_BITS-1:0] viol_reg;
    reg  [`DDRTM_V_BITS-1:0] viol_next;
    reg  [`DDRTM_V_BITS-1:0] viol_set;
    wire [`DDRTM_V_BITS-1:0] viol_clr;

    // Mode register state
    reg  [2:0]  bl_reg;
    reg  [2:0]  cl_reg;
    reg  [2:0]  al_reg;
    reg  [2:0]  wr_reg;
    reg         slow_exit_reg;
    reg         strobe_se_reg;

    // Pin history
    reg         cke_prev_reg;
    reg         odt_prev_reg;
    reg  [3:0]  bank_open_reg;
    reg  [2:0]  odt_pipe_reg;

    // Timer controls
    wire [3:0]  ras_busy;
    wire        mrs_busy;
    wire        cke_busy;
    wire        wtr_busy;
    wire        rtp_busy;
    wire        xp_busy;
    wire        xard_busy;
    wire        anpd_busy;
    wire        axpd_busy;
    wire        dal_busy;

    wire check_en = ctrl_reg[`DDRTM_CTRL_CHECK_BIT];
    wire speed_hi = ctrl_reg[`DDRTM_CTRL_SPEED_BIT];

    // Reset cycle counts, cut to the width of their fields
    localparam [31:0] RP_CYC  = `DDRTM_RP_CYC;
    localparam [31:0] RAS_CYC = `DDRTM_RAS_CYC;
    localparam [31:0] RTP_CYC = `DDRTM_RTP_CYC;

    ddrtm_ahb_slave u_bus (
        .clk       (clk),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .wr_en     (wr_en),
        .reg_addr  (reg_addr),
        .wr_data   (wr_data),
        .rd_data   (rd_data)
    );

    // Command decode, valid only while clock enable stays high
    wire cmd_ok  = ~mem_cs_n & mem_cke & cke_prev_reg;
    wire [2:0] cmd = {mem_ras_n, mem_cas_n, mem_we_n};
    wire is_mrs  = cmd_ok & (cmd == 3'b000);
    wire is_pre  = cmd_ok & (cmd == 3'b010);
    wire is_act  = cmd_ok & (cmd == 3'b011);
    wire is_wr   = cmd_ok & (cmd == 3'b100);
    wire is_rd   = cmd_ok & (cmd == 3'b101);
    wire any_cmd = cmd_ok & (cmd != 3'b111);
    wire auto_pc = mem_addr[10];
    wire cke_chg = mem_cke ^ cke_prev_reg;
    wire cke_up  = mem_cke & ~cke_prev_reg;
    wire cke_dn  = ~mem_cke & cke_prev_reg;
    wire odt_chg = mem_odt ^ odt_prev_reg;

    // Latency arithmetic, all six bits wide
    wire [5:0] al6   = {3'b000, al_reg};
    wire [5:0] cl6   = {3'b000, cl_reg};
    wire [5:0] half6 = (bl_reg == `DDRTM_BL8_CODE) ? 6'd4 : 6'd2;
    wire [5:0] wr6   = {3'b000, wr_reg} + 6'd1;
    wire [5:0] rp6   = {1'b0, rp_reg};
    wire [5:0] rtp6  = {2'b00, rtp_reg};

    wire [5:0] rd_pre  = al6 + half6;
    wire [5:0] rtp_val = (rd_pre > rtp6) ? rd_pre : rtp6;
    wire [5:0] wtr_val = al6 + cl6 - 6'd1 + half6 + `DDRTM_WTR_GAP;
    wire [5:0] dal_val = al6 + cl6 - 6'd1 + half6 + wr6 + rp6;
    wire [5:0] xp_val  = speed_hi ? `DDRTM_XP_HIGH : `DDRTM_XP_LOW;
    wire [5:0] xards   = `DDRTM_XARDS_BASE - al6;
    wire [5:0] xrd_val = (bank_open_reg == 4'h0) ? 6'd0 :
                         (slow_exit_reg ? xards : `DDRTM_XARD_FAST);

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_bank
            ddrtm_gap_timer #(.W(TW)) u_ras (
                .clk   (clk),
                .rst_n (rst_n),
                .load  (is_act & (mem_ba == gb)),
                .value ({1'b0, ras_reg}),
                .busy  (ras_busy[gb])
            );
        end
    endgenerate

    ddrtm_gap_timer #(.W(TW)) u_mrs (
        .clk (clk), .rst_n (rst_n), .load (is_mrs),
        .value (`DDRTM_MRS_GAP), .busy (mrs_busy)
    );

    ddrtm_gap_timer #(.W(TW)) u_cke (
        .clk (clk), .rst_n (rst_n), .load (cke_chg),
        .value (`DDRTM_CKE_HOLD), .busy (cke_busy)
    );

    ddrtm_gap_timer #(.W(TW)) u_wtr (
        .clk (clk), .rst_n (rst_n), .load (is_wr),
        .value (wtr_val), .busy (wtr_busy)
    );

    ddrtm_gap_timer #(.W(TW)) u_rtp (
        .clk (clk), .rst_n (rst_n), .load (is_rd),
        .value (rtp_val), .busy (rtp_busy)
    );

    ddrtm_gap_timer #(.W(TW)) u_xp (
        .clk (clk), .rst_n (rst_n), .load (cke_up),
        .value (xp_val), .busy (xp_busy)
    );

    ddrtm_gap_timer #(.W(TW)) u_xard (
        .clk (clk), .rst_n (rst_n), .load (cke_up),
        .value (xrd_val), .busy (xard_busy)
    );

    ddrtm_gap_timer #(.W(TW)) u_anpd (
        .clk (clk), .rst_n (rst_n), .load (odt_chg),
        .value (`DDRTM_ANPD_GAP), .busy (anpd_busy)
    );

    ddrtm_gap_timer #(.W(TW)) u_axpd (
        .clk (clk), .rst_n (rst_n), .load (cke_up),
        .value (`DDRTM_AXPD_GAP), .busy (axpd_busy)
    );

    ddrtm_gap_timer #(.W(TW)) u_dal (
        .clk (clk), .rst_n (rst_n), .load (is_wr & auto_pc),
        .value (dal_val), .busy (dal_busy)
    );

    // Spacing faults seen this cycle
    always @* begin
        viol_set = {`DDRTM_V_BITS{1'b0}};
        viol_set[`DDRTM_V_MRS]  = is_mrs & mrs_busy;
        viol_set[`DDRTM_V_CKE]  = cke_chg & cke_busy;
        viol_set[`DDRTM_V_WTR]  = is_rd & wtr_busy;
        viol_set[`DDRTM_V_RTP]  = is_pre & rtp_busy;
        viol_set[`DDRTM_V_RAS]  = is_pre & (auto_pc ? (|ras_busy) : ras_busy[mem_ba]);
        viol_set[`DDRTM_V_XP]   = any_cmd & xp_busy;
        viol_set[`DDRTM_V_XARD] = is_rd & xard_busy;
        viol_set[`DDRTM_V_ANPD] = cke_dn & anpd_busy;
        viol_set[`DDRTM_V_AXPD] = odt_chg & axpd_busy;
        viol_set[`DDRTM_V_DAL]  = is_act & dal_busy;
        if (!check_en) begin
            viol_set = {`DDRTM_V_BITS{1'b0}};
        end
    end

    // Write one to clear; a new fault in the same cycle wins
    assign viol_clr = (wr_en && reg_addr == `DDRTM_VIOL_OFS) ?
                      wr_data[`DDRTM_V_BITS-1:0] : {`DDRTM_V_BITS{1'b0}};

    always @* begin
        viol_next = (viol_reg & ~viol_clr) | viol_set;
    end

    // Software writes to control and timing
    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg  <= `DDRTM_CTRL_RESET;
            rp_reg    <= RP_CYC[4:0];
            ras_reg   <= RAS_CYC[4:0];
            rtp_reg   <= RTP_CYC[3:0];
            viol_reg  <= {`DDRTM_V_BITS{1'b0}};
            viol_flag <= 1'b0;
        end else begin
            viol_reg  <= viol_next;
            viol_flag <= |viol_next;
            if (wr_en && reg_addr == `DDRTM_CTRL_OFS) begin
                ctrl_reg <= wr_data[1:0];
            end
            if (wr_en && reg_addr == `DDRTM_TIMING_OFS) begin
                rp_reg  <= wr_data[`DDRTM_TIM_RP_LSB +: 5];
                ras_reg <= wr_data[`DDRTM_TIM_RAS_LSB +: 5];
                rtp_reg <= wr_data[`DDRTM_TIM_RTP_LSB +: 4];
            end
        end
    end

    // Mode register capture from mode set commands
    always @(posedge clk) begin
        if (!rst_n) begin
            bl_reg        <= `DDRTM_BL_RESET;
            cl_reg        <= `DDRTM_CL_RESET;
            al_reg        <= `DDRTM_AL_RESET;
            wr_reg        <= `DDRTM_WR_RESET;
            slow_exit_reg <= 1'b0;
            strobe_se_reg <= 1'b0;
        end else if (is_mrs && mem_ba == 2'b00) begin
            bl_reg        <= mem_addr[2:0];
            cl_reg        <= mem_addr[6:4];
            wr_reg        <= mem_addr[11:9];
            slow_exit_reg <= mem_addr[`DDRTM_MR_SLOW_BIT];
        end else if (is_mrs && mem_ba == 2'b01) begin
            al_reg        <= mem_addr[5:3];
            strobe_se_reg <= mem_addr[`DDRTM_EMR_STROBE_BIT];
        end
    end

    // Open bank tracking; no limit on strobe postamble
    always @(posedge clk) begin
        if (!rst_n) begin
            bank_open_reg <= 4'h0;
            cke_prev_reg  <= 1'b0;
            odt_prev_reg  <= 1'b0;
        end else begin
            cke_prev_reg <= mem_cke;
            odt_prev_reg <= mem_odt;
            if (is_act) begin
                bank_open_reg[mem_ba] <= 1'b1;
            end else if (is_pre && auto_pc) begin
                bank_open_reg <= 4'h0;
            end else if (is_pre || ((is_rd || is_wr) && auto_pc)) begin
                bank_open_reg[mem_ba] <= 1'b0;
            end
        end
    end

    // Termination control delay line
    always @(posedge clk) begin
        if (!rst_n) begin
            odt_pipe_reg <= 3'h0;
            term_en      <= 1'b0;
        end else begin
            odt_pipe_reg <= {odt_pipe_reg[1:0], mem_odt};
            // on two edges after high; off one edge later
            term_en <= odt_pipe_reg[1] | (odt_pipe_reg[2] & term_en);
        end
    end

    // Register read mux
    always @* begin
        rd_data = 32'h0000_0000;
        case (reg_addr)
            `DDRTM_CTRL_OFS: begin
                rd_data[1:0] = ctrl_reg;
            end
            `DDRTM_TIMING_OFS: begin
                rd_data[`DDRTM_TIM_RP_LSB +: 5]  = rp_reg;
                rd_data[`DDRTM_TIM_RAS_LSB +: 5] = ras_reg;
                rd_data[`DDRTM_TIM_RTP_LSB +: 4] = rtp_reg;
            end
            `DDRTM_VIOL_OFS: begin
                rd_data[`DDRTM_V_BITS-1:0] = viol_reg;
            end
            `DDRTM_MODE_OFS: begin
                rd_data[2:0]   = bl_reg;
                rd_data[6:4]   = cl_reg;
                rd_data[10:8]  = al_reg;
                rd_data[14:12] = wr_reg;
                rd_data[16]    = slow_exit_reg;
                rd_data[17]    = strobe_se_reg;
                rd_data[18]    = term_en;
                rd_data[19]    = cke_prev_reg;
                rd_data[23:20] = bank_open_reg;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // Size field unused: only whole-word transfers
    wire unused_ok = &hsize | 1'b1;

endmodule // ddrtm_monitor
